// file: hdl/exec_map.vh
// Constants for the instruction execute block: opcode codes, limits,
// software port offsets and field positions.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

// ----------------------------------------------------------------
// Opcode codes presented by the fetch stage on i_op
// ----------------------------------------------------------------
`define OP_IDLE_OP 5'h00
`define OP_OR_IMMEDIATE 5'h01
`define OP_READ_CTRL_ONE 5'h02
`define OP_WRITE_CTRL_ONE 5'h03
`define OP_LONG_SUB_JUMP 5'h04
`define OP_LONG_JUMP 5'h05
`define OP_LOAD_IMMEDIATE 5'h06
`define OP_STORE_WORKING 5'h07
`define OP_COPY_FILE_REG 5'h08
`define OP_LITERAL_EXIT 5'h09
`define OP_IRQ_EXIT 5'h0a
`define OP_SUB_EXIT 5'h0b
`define OP_ROTATE_LEFT 5'h0c
`define OP_ROTATE_RIGHT 5'h0d
`define OP_SUB_BORROW_REG 5'h0e
`define OP_SUB_BORROW_IMM 5'h0f
`define OP_READ_CTRL_TWO 5'h10
`define OP_WRITE_CTRL_TWO 5'h11
`define OP_HALT_ENTRY 5'h12

// ----------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------
`define PAGE_ONE_READ_MIN 4'h5
`define STACK_DEPTH 8
`define STACK_PTR_W 4
`define PC_RESET 10'h000
`define DATA_RESET 8'h00
`define WDT_DIV_LAST 8'hff

// ----------------------------------------------------------------
// Software port offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 4'h0
`define OFS_STATUS 4'h1
`define OFS_WORKING 4'h2
`define OFS_PC_LOW 4'h3
`define OFS_PC_HIGH 4'h4
`define OFS_WATCHDOG 4'h5
`define OFS_STACK_PTR 4'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_WDT_EN 0
`define CTL_WAKE 1
`define ST_CARRY 0
`define ST_HALF 1
`define ST_ZERO 2
`define ST_PD 3
`define ST_TO 4
`define ST_GIE 5
`define ST_HALT 6
`define ST_BUSY 7

`endif

// file: hdl/call_stack.v
// Return address stack for calls and returns, eight entries deep.
// Assumes push and pop never arrive in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"

module call_stack (
    // Clock and reset
    input wire i_mclk,
    input wire i_reset,
    // Push and pop
    input wire i_push,
    input wire i_pop,
    input wire [9:0] i_push_addr,
    // Stack state
    output wire [9:0] o_top,
    output wire [3:0] o_depth
);

reg [9:0] entry_reg [0:`STACK_DEPTH-1];
reg [3:0] ptr_reg;
wire [2:0] wr_idx;
wire [2:0] rd_idx;

// Push writes above the top, wrapping like the real hardware
assign wr_idx = ptr_reg[2:0];
assign rd_idx = ptr_reg[2:0] - 3'h1;
assign o_top = entry_reg[rd_idx];
assign o_depth = ptr_reg;

// ----------------------------------------------------------------
// Storage, one slot per entry
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < `STACK_DEPTH; g = g + 1) begin : slot
        always @(posedge i_mclk) begin
            if (i_reset) begin
                entry_reg[g] <= `PC_RESET;
            end else if (i_push && wr_idx == g) begin
                entry_reg[g] <= i_push_addr;
            end
        end
    end
endgenerate

// Pointer moves up on push, down on pop
always @(posedge i_mclk) begin
    if (i_reset) begin
        ptr_reg <= 4'h0;
    end else if (i_push && ptr_reg != 4'h8) begin
        ptr_reg <= ptr_reg + 4'h1;
    end else if (i_pop && ptr_reg != 4'h0) begin
        ptr_reg <= ptr_reg - 4'h1;
    end
end

endmodule
`default_nettype wire

// file: hdl/exec_subset.v
// Execute stage for one subset of an 8-bit microcontroller core.
// Assumes the fetch stage presents one decoded instruction per cycle
// while o_ready is high, and software uses the plain register port.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"

module exec_subset (
    // Clock and reset
    input wire i_mclk,
    input wire i_reset,
    // Instruction from fetch
    input wire i_valid,
    input wire [4:0] i_op,
    input wire [9:0] i_operand,
    input wire i_dest,
    // Interrupt request from peripherals
    input wire i_irq_req,
    // Software register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // Core state
    output reg o_ready,
    output reg [9:0] o_pc,
    output reg [7:0] o_acc,
    output reg o_halt,
    output reg o_irq_take
);

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [7:0] acc_reg;
reg [9:0] pc_reg;
reg carry_reg;
reg half_borrow_bit_reg;
reg zero_reg;
reg global_irq_enable_reg;
reg watchdog_expiry_flag_reg;
reg powerdown_flag_reg;
reg halt_reg;
reg busy_reg;
reg wdt_en_reg;
reg [7:0] watchdog_counter_reg;
reg [7:0] watchdog_divider_reg;
reg [7:0] file_reg [0:63];
reg [7:0] page_one_reg [0:15];
reg [7:0] page_two_reg [0:15];

// Next values
reg [7:0] acc_next;
reg [9:0] pc_next;
reg carry_next;
reg half_next;
reg zero_next;
reg gie_next;
reg halt_next;
reg busy_next;
reg file_we;
reg one_we;
reg two_we;
reg push;
reg pop;
reg wdt_clear;
reg flag_write;

wire [9:0] stack_top;
wire [3:0] stack_depth;
wire exec;
wire [5:0] faddr;
wire [3:0] paddr;
wire [7:0] literal;
wire [7:0] fval;
wire [7:0] sub_src;
wire [8:0] sub_sum;
wire [4:0] sub_low;
wire [7:0] rot_left;
wire [7:0] rot_right;
reg [7:0] result;

// ----------------------------------------------------------------
// Operand fields and datapath
// ----------------------------------------------------------------
assign exec = i_valid && !busy_reg && !halt_reg;
assign faddr = i_operand[5:0];
assign paddr = i_operand[3:0];
assign literal = i_operand[7:0];
assign fval = file_reg[faddr];

// Borrow subtract shares one adder for both sources
assign sub_src = (i_op == `OP_SUB_BORROW_IMM) ? literal : fval;
assign sub_sum = {1'b0, sub_src} + {1'b0, ~acc_reg} + {8'h00, carry_reg};
assign sub_low = {1'b0, sub_src[3:0]} + {1'b0, ~acc_reg[3:0]}
    + {4'h0, carry_reg};

// Rotates through carry
assign rot_left = {fval[6:0], carry_reg};
assign rot_right = {carry_reg, fval[7:1]};

// ----------------------------------------------------------------
// Return address stack
// ----------------------------------------------------------------
call_stack u_stack (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_push(push),
    .i_pop(pop),
    .i_push_addr(pc_reg + 10'h001),
    .o_top(stack_top),
    .o_depth(stack_depth)
);

// ----------------------------------------------------------------
// Decode and execute
// ----------------------------------------------------------------
always @* begin
    acc_next = acc_reg;
    pc_next = pc_reg;
    carry_next = carry_reg;
    half_next = half_borrow_bit_reg;
    zero_next = zero_reg;
    gie_next = global_irq_enable_reg;
    halt_next = halt_reg;
    busy_next = 1'b0;
    file_we = 1'b0;
    one_we = 1'b0;
    two_we = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    wdt_clear = 1'b0;
    flag_write = 1'b0;
    result = fval;
    if (exec) begin
        pc_next = pc_reg + 10'h001;
        case (i_op)
            `OP_IDLE_OP: begin
                pc_next = pc_reg + 10'h001;
            end
            `OP_OR_IMMEDIATE: begin
                acc_next = acc_reg | literal;
                zero_next = ((acc_reg | literal) == 8'h00);
            end
            `OP_READ_CTRL_ONE: begin
                // Indices below five read as zero
                if (paddr >= `PAGE_ONE_READ_MIN) begin
                    acc_next = page_one_reg[paddr];
                end else begin
                    acc_next = `DATA_RESET;
                end
            end
            `OP_WRITE_CTRL_ONE: begin
                one_we = 1'b1;
            end
            `OP_LONG_SUB_JUMP: begin
                push = 1'b1;
                pc_next = i_operand;
                busy_next = 1'b1;
            end
            `OP_LONG_JUMP: begin
                pc_next = i_operand;
                busy_next = 1'b1;
            end
            `OP_LOAD_IMMEDIATE: begin
                acc_next = literal;
            end
            `OP_STORE_WORKING: begin
                file_we = 1'b1;
                result = acc_reg;
            end
            `OP_COPY_FILE_REG: begin
                flag_write = 1'b1;
                result = fval;
                zero_next = (fval == 8'h00);
            end
            `OP_LITERAL_EXIT: begin
                acc_next = literal;
                pop = 1'b1;
                pc_next = stack_top;
                gie_next = 1'b1;
                busy_next = 1'b1;
            end
            `OP_IRQ_EXIT: begin
                pop = 1'b1;
                pc_next = stack_top;
                gie_next = 1'b1;
                busy_next = 1'b1;
            end
            `OP_SUB_EXIT: begin
                pop = 1'b1;
                pc_next = stack_top;
                busy_next = 1'b1;
            end
            `OP_ROTATE_LEFT: begin
                flag_write = 1'b1;
                result = rot_left;
                carry_next = fval[7];
            end
            `OP_ROTATE_RIGHT: begin
                flag_write = 1'b1;
                result = rot_right;
                carry_next = fval[0];
            end
            `OP_SUB_BORROW_REG: begin
                flag_write = 1'b1;
                result = sub_sum[7:0];
                carry_next = sub_sum[8];
                half_next = sub_low[4];
                zero_next = (sub_sum[7:0] == 8'h00);
            end
            `OP_SUB_BORROW_IMM: begin
                acc_next = sub_sum[7:0];
                carry_next = sub_sum[8];
                half_next = sub_low[4];
                zero_next = (sub_sum[7:0] == 8'h00);
            end
            `OP_READ_CTRL_TWO: begin
                acc_next = page_two_reg[paddr];
            end
            `OP_WRITE_CTRL_TWO: begin
                two_we = 1'b1;
            end
            `OP_HALT_ENTRY: begin
                wdt_clear = 1'b1;
                halt_next = 1'b1;
            end
            default: begin
                pc_next = pc_reg + 10'h001;
            end
        endcase
        // Result routing for ops that carry a destination bit
        if (flag_write) begin
            if (i_dest) begin
                file_we = 1'b1;
            end else begin
                acc_next = result;
            end
        end
    end
    // Software wake releases halt mode
    if (halt_reg && i_wr && i_addr == `OFS_CONTROL
        && i_wdata[`CTL_WAKE]) begin
        halt_next = 1'b0;
    end
end

// ----------------------------------------------------------------
// Core registers
// ----------------------------------------------------------------
always @(posedge i_mclk) begin
    if (i_reset) begin
        acc_reg <= `DATA_RESET;
        pc_reg <= `PC_RESET;
        carry_reg <= 1'b0;
        half_borrow_bit_reg <= 1'b0;
        zero_reg <= 1'b0;
        global_irq_enable_reg <= 1'b0;
        halt_reg <= 1'b0;
        busy_reg <= 1'b0;
    end else begin
        acc_reg <= acc_next;
        pc_reg <= pc_next;
        carry_reg <= carry_next;
        half_borrow_bit_reg <= half_next;
        zero_reg <= zero_next;
        global_irq_enable_reg <= gie_next;
        halt_reg <= halt_next;
        busy_reg <= busy_next;
    end
end

// Reset status bits and halt entry update
always @(posedge i_mclk) begin
    if (i_reset) begin
        watchdog_expiry_flag_reg <= 1'b1;
        powerdown_flag_reg <= 1'b1;
    end else if (wdt_clear) begin
        watchdog_expiry_flag_reg <= 1'b1;
        powerdown_flag_reg <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Register files
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 64; g = g + 1) begin : file_slot
        always @(posedge i_mclk) begin
            if (i_reset) begin
                file_reg[g] <= `DATA_RESET;
            end else if (file_we && faddr == g) begin
                file_reg[g] <= result;
            end
        end
    end
    for (g = 0; g < 16; g = g + 1) begin : page_slot
        always @(posedge i_mclk) begin
            if (i_reset) begin
                page_one_reg[g] <= `DATA_RESET;
                page_two_reg[g] <= `DATA_RESET;
            end else begin
                if (one_we && paddr == g) begin
                    page_one_reg[g] <= acc_reg;
                end
                if (two_we && paddr == g) begin
                    page_two_reg[g] <= acc_reg;
                end
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// Watchdog divider and counter
// ----------------------------------------------------------------
always @(posedge i_mclk) begin
    if (i_reset) begin
        watchdog_divider_reg <= 8'h00;
        watchdog_counter_reg <= 8'h00;
    end else if (wdt_clear) begin
        watchdog_divider_reg <= 8'h00;
        watchdog_counter_reg <= 8'h00;
    end else if (wdt_en_reg) begin
        watchdog_divider_reg <= watchdog_divider_reg + 8'h01;
        if (watchdog_divider_reg == `WDT_DIV_LAST) begin
            watchdog_counter_reg <= watchdog_counter_reg + 8'h01;
        end
    end
end

// ----------------------------------------------------------------
// Software port
// ----------------------------------------------------------------
// Control write: watchdog enable
always @(posedge i_mclk) begin
    if (i_reset) begin
        wdt_en_reg <= 1'b0;
    end else if (i_wr && i_addr == `OFS_CONTROL) begin
        wdt_en_reg <= i_wdata[`CTL_WDT_EN];
    end
end

// Read data one cycle after the strobe, zero otherwise
always @(posedge i_mclk) begin
    if (i_reset) begin
        o_rdata <= 8'h00;
    end else if (i_rd) begin
        case (i_addr)
            `OFS_CONTROL: o_rdata <= {7'h00, wdt_en_reg};
            `OFS_STATUS: o_rdata <= {busy_reg, halt_reg,
                global_irq_enable_reg, watchdog_expiry_flag_reg,
                powerdown_flag_reg, zero_reg, half_borrow_bit_reg,
                carry_reg};
            `OFS_WORKING: o_rdata <= acc_reg;
            `OFS_PC_LOW: o_rdata <= pc_reg[7:0];
            `OFS_PC_HIGH: o_rdata <= {6'h00, pc_reg[9:8]};
            `OFS_WATCHDOG: o_rdata <= watchdog_counter_reg;
            `OFS_STACK_PTR: o_rdata <= {4'h0, stack_depth};
            default: o_rdata <= 8'h00;
        endcase
    end else begin
        o_rdata <= 8'h00;
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
always @(posedge i_mclk) begin
    if (i_reset) begin
        o_ready <= 1'b0;
        o_pc <= `PC_RESET;
        o_acc <= `DATA_RESET;
        o_halt <= 1'b0;
        o_irq_take <= 1'b0;
    end else begin
        o_ready <= !busy_next && !halt_next;
        o_pc <= pc_next;
        o_acc <= acc_next;
        o_halt <= halt_next;
        o_irq_take <= i_irq_req && gie_next;
    end
end

endmodule
`default_nettype wire

// file: testbench/exec_subset_sva.sv
// Port checks for the instruction execute block.
// Assumes exec_map.vh on the include path; bound in at the foot.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"

module exec_subset_sva (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Instruction and software strobes
    input wire logic i_valid,
    input wire logic [4:0] i_op,
    input wire logic [9:0] i_operand,
    input wire logic i_wr,
    input wire logic i_rd,
    // Core state
    input wire logic [7:0] o_rdata,
    input wire logic o_ready,
    input wire logic [9:0] o_pc,
    input wire logic [7:0] o_acc,
    input wire logic o_halt
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    // ----------------------------------------------------------------
    // Instruction acceptance
    // ----------------------------------------------------------------
    sequence took(logic [4:0] c);
        i_valid && o_ready && !o_halt && i_op == c;
    endsequence
    sequence took_long;
        i_valid && o_ready && !o_halt && (i_op inside {`OP_LONG_JUMP,
            `OP_LONG_SUB_JUMP, `OP_LITERAL_EXIT, `OP_IRQ_EXIT,
            `OP_SUB_EXIT});
    endsequence
    sequence dead_then_ready;
        !o_ready ##1 o_ready;
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_long_dead_cycle: assert property (
        took_long |=> dead_then_ready)
        else $error("two-cycle op without one dead cycle");
    a_jump_target: assert property (
        took(`OP_LONG_JUMP) |=> o_pc == $past(i_operand))
        else $error("long jump target not loaded");
    a_call_target: assert property (
        took(`OP_LONG_SUB_JUMP) |=> o_pc == $past(i_operand))
        else $error("call target not loaded");
    a_load_literal: assert property (
        took(`OP_LOAD_IMMEDIATE) |=> o_acc == $past(i_operand[7:0]))
        else $error("literal not loaded");
    a_or_literal: assert property (
        took(`OP_OR_IMMEDIATE)
        |=> o_acc == ($past(o_acc) | $past(i_operand[7:0])))
        else $error("or literal result wrong");
    a_exit_literal: assert property (
        took(`OP_LITERAL_EXIT) |=> o_acc == $past(i_operand[7:0]))
        else $error("exit literal not loaded");
    a_idle_advance: assert property (
        took(`OP_IDLE_OP)
        |=> o_pc == $past(o_pc) + 10'h001 && $stable(o_acc))
        else $error("idle op did more than advance");
    a_halt_enter: assert property (took(`OP_HALT_ENTRY) |=> o_halt)
        else $error("halt not entered");
    a_halt_holds: assert property (
        o_halt && !i_wr |=> o_halt && $stable(o_pc) && $stable(o_acc))
        else $error("state moved while halted");
    a_read_quiet: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read reply");
endmodule

bind exec_subset exec_subset_sva u_sva (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_valid(i_valid), .i_op(i_op), .i_operand(i_operand), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_ready(o_ready), .o_pc(o_pc),
    .o_acc(o_acc), .o_halt(o_halt));
`default_nettype wire

// file: testbench/exec_subset_tb.sv
// Self-checking bench for the instruction execute block.
// Assumes exec_map.vh on the include path and the checker bound in.
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.vh"

module exec_subset_tb;
    // ----------------------------------------------------------------
    // Signals and bench state
    // ----------------------------------------------------------------
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic i_valid = 1'b0;
    logic [4:0] i_op = 5'h00;
    logic [9:0] i_operand = 10'h000;
    logic i_dest = 1'b0;
    logic i_irq_req = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    wire logic [7:0] o_rdata;
    wire logic o_ready;
    wire logic [9:0] o_pc;
    wire logic [7:0] o_acc;
    wire logic o_halt;
    wire logic o_irq_take;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h25cc936a;
    logic [7:0] acc, mem, r, v;
    logic [10:0] res;
    logic [5:0] f;
    logic [3:0] k;
    logic cy;

    // Clock and cycle ceiling
    always #4 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            print_verdict();
        end
    end

    exec_subset DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_valid(i_valid),
        .i_op(i_op), .i_operand(i_operand), .i_dest(i_dest),
        .i_irq_req(i_irq_req), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ready(o_ready),
        .o_pc(o_pc), .o_acc(o_acc), .o_halt(o_halt),
        .o_irq_take(o_irq_take));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Subtract with borrow: {carry, half, zero, result}
    function automatic logic [10:0] sbc(input logic [7:0] a,
            input logic [7:0] w, input logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~w} + c;
        h = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + c;
        return {s[8], h[4], s[7:0] == 8'h00, s[7:0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One instruction, then room for a dead cycle
    task automatic op(input logic [4:0] c, input logic [9:0] x,
            input logic d);
        i_valid <= 1'b1;
        i_op <= c;
        i_operand <= x;
        i_dest <= d;
        @(posedge i_mclk);
        i_valid <= 1'b0;
        repeat (2) @(posedge i_mclk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
        d = o_rdata;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic print_verdict();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_mclk);
        rd(`OFS_STATUS, v);
        chk({o_pc, v}, {`PC_RESET, 8'h18});
        cy = 1'b0;
        // Data path with random values and a zero-result corner
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            f = seed[29:24];
            op(`OP_LOAD_IMMEDIATE, {2'b00, seed[7:0]}, 1'b0);
            chk(o_acc, seed[7:0]);
            op(`OP_STORE_WORKING, {4'h0, f}, 1'b0);
            op(`OP_ROTATE_LEFT, {4'h0, f}, 1'b0);
            chk(o_acc, {seed[6:0], cy});
            op(`OP_ROTATE_RIGHT, {4'h0, f}, 1'b1);
            mem = {seed[7], seed[7:1]};
            cy = seed[0];
            op(`OP_COPY_FILE_REG, {4'h0, f}, 1'b0);
            chk(o_acc, mem);
            acc = seed[15:8];
            r = (i == 0) ? acc + 8'h01 - cy : seed[23:16];
            op(`OP_LOAD_IMMEDIATE, {2'b00, acc}, 1'b0);
            op(`OP_SUB_BORROW_IMM, {2'b00, r}, 1'b0);
            res = sbc(r, acc, cy);
            rd(`OFS_STATUS, v);
            chk({o_acc, v[0], v[1], v[2]}, {res[7:0], res[10:8]});
            cy = res[10];
            acc = res[7:0];
            op(`OP_SUB_BORROW_REG, {4'h0, f}, i[0]);
            res = sbc(mem, acc, cy);
            rd(`OFS_STATUS, v);
            r = i[0] ? acc : res[7:0];
            chk({o_acc, v[0], v[1], v[2]}, {r, res[10:8]});
            cy = res[10];
            op(`OP_COPY_FILE_REG, {4'h0, f}, 1'b0);
            chk(o_acc, i[0] ? res[7:0] : mem);
            acc = o_acc;
            r = seed[31:24] & {8{i[1]}};
            op(`OP_OR_IMMEDIATE, {2'b00, r}, 1'b0);
            rd(`OFS_STATUS, v);
            chk({o_acc, v[2]}, {acc | r, (acc | r) == 8'h00});
        end
        // Control pages written then read back
        for (int p = 0; p < 2; p++) begin
            seed = xs(seed);
            k = p ? seed[11:8] : 4'h5 + (seed[11:8] % 4'hb);
            op(`OP_LOAD_IMMEDIATE, {2'b00, seed[7:0]}, 1'b0);
            op(p ? `OP_WRITE_CTRL_TWO : `OP_WRITE_CTRL_ONE, {6'h00, k}, 1'b0);
            op(`OP_LOAD_IMMEDIATE, {2'b00, ~seed[7:0]}, 1'b0);
            op(p ? `OP_READ_CTRL_TWO : `OP_READ_CTRL_ONE, {6'h00, k}, 1'b0);
            chk(o_acc, seed[7:0]);
        end
        // Jumps, nested calls and returns
        op(`OP_LONG_JUMP, 10'h3f7, 1'b0);
        chk(o_pc, 10'h3f7);
        op(`OP_LONG_SUB_JUMP, 10'h155, 1'b0);
        op(`OP_LONG_SUB_JUMP, 10'h2aa, 1'b0);
        rd(`OFS_STACK_PTR, v);
        chk({o_pc, v}, {10'h2aa, 8'h02});
        op(`OP_SUB_EXIT, 10'h000, 1'b0);
        chk(o_pc, 10'h156);
        op(`OP_IDLE_OP, 10'h000, 1'b0);
        chk(o_pc, 10'h157);
        i_irq_req <= 1'b1;
        rd(`OFS_STATUS, v);
        chk({v[5], o_irq_take}, 2'b00);
        op(`OP_LITERAL_EXIT, 10'h0c3, 1'b0);
        rd(`OFS_STACK_PTR, v);
        chk({o_pc, o_acc, v}, {10'h3f8, 8'hc3, 8'h00});
        rd(`OFS_STATUS, v);
        chk({v[5], o_irq_take}, 2'b11);
        // Second reset, then interrupt exit
        i_reset <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_mclk);
        chk(o_irq_take, 1'b0);
        op(`OP_LONG_SUB_JUMP, 10'h040, 1'b0);
        op(`OP_IRQ_EXIT, 10'h000, 1'b0);
        rd(`OFS_STATUS, v);
        chk({o_pc, v[5], o_irq_take}, {10'h001, 2'b11});
        // Halt with the watchdog running
        wr(`OFS_CONTROL, 8'h01);
        repeat (600) @(posedge i_mclk);
        rd(`OFS_WATCHDOG, v);
        chk(v == 8'h00, 1'b0);
        acc = o_acc;
        op(`OP_HALT_ENTRY, 10'h000, 1'b0);
        rd(`OFS_WATCHDOG, v);
        chk(v, 8'h00);
        rd(`OFS_STATUS, v);
        chk({o_halt, v[6], v[4], v[3]}, 4'b1110);
        op(`OP_LOAD_IMMEDIATE, 10'h05a, 1'b0);
        chk(o_acc, acc);
        wr(`OFS_CONTROL, 8'h02);
        chk(o_halt, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
